// *** verification/test_abs_top.sv ***
`timescale 1ns/1ps
module test_abs_top;
  import abs_pkg::*;
  logic clk, rst, conv, cal, cmp, track, done, busy;
  abs_sfr_req_type req;
  abs_cfg_type cfg;
  logic [7:0] rdata, d;
  logic [11:0] dac, res, tgt;
  int fail_count, n_checks, cyc;

  abs_top dut_u (.CORE_CLK_I(clk), .RST_I(rst), .SFR_REQ_I(req),
    .SFR_RDATA_O(rdata), .CONV_START_I(conv), .CAL_START_I(cal),
    .CFG_I(cfg), .CMP_I(cmp), .TRACK_O(track), .DAC_CODE_O(dac),
    .RESULT_O(res), .DONE_O(done), .BUSY_O(busy));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // comparator follows the trial code, so the SAR must land on tgt
  always @(negedge clk) cmp <= (dac > tgt);

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  task automatic chk(input string nm, input logic [11:0] got, exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic range(input string nm, input int v, lo, hi);
    chk(nm, 12'(v >= lo && v <= hi), 12'h001);
  endtask : range

  task automatic sfr(input logic [7:0] a, input logic [7:0] w, input bit wr);
    @(negedge clk);
    req = '{addr: a, wdata: w, wr: wr, rd: !wr};
    @(negedge clk);
    req = '0;
    d = rdata;
  endtask : sfr

  // one conversion; checks result, phase lengths and busy
  task automatic convert(input logic [11:0] t, input logic [1:0] dv, ac);
    int n, tr, k;
    k = 2 << dv;
    n = 0;
    tr = 0;
    @(negedge clk);
    tgt = t;
    cfg = '{clk_div: dv, acq_sel: ac};
    conv = 1'b1;
    @(negedge clk);
    conv = 1'b0;
    sfr(ABS_STATUS_ADDR, 8'h00, 1'b0);
    chk("busy_read", {4'h0, d}, 12'h080);
    n = 2;
    while (!done && n < 2000) begin
      if (track) tr++;
      @(negedge clk);
      n++;
    end
    chk("result", res, t);
    chk("track_at_done", {11'h0, track}, 12'h000);
    range("track_len", tr, (1 + ac) * k, (3 + ac) * k + 2);
    range("conv_len", n, (16 + ac) * k, (18 + ac) * k + 4);
    @(negedge clk);
    chk("done_pulse", {11'h0, done}, 12'h000);
    sfr(ABS_STATUS_ADDR, 8'h00, 1'b0);
    chk("busy_clear", {4'h0, d}, 12'h000);
  endtask : convert

  task automatic reset_state;
    chk("result_rst", res, 12'h000);
    sfr(ABS_STATUS_ADDR, 8'h00, 1'b0);
    chk("status_rst", {4'h0, d}, {4'h0, ABS_STATUS_RESET});
    sfr(8'hf4, 8'h00, 1'b0);
    chk("unmapped", {4'h0, d}, 12'h000);
  endtask : reset_state

  task automatic write_busy;
    // reserved bits written as zero, busy bit as one
    sfr(ABS_STATUS_ADDR, 8'h80, 1'b1);
    sfr(ABS_STATUS_ADDR, 8'h00, 1'b0);
    chk("busy_write", {4'h0, d}, 12'h000);
  endtask : write_busy

  task automatic calibrate;
    int n;
    n = 0;
    @(negedge clk);
    cfg = '{clk_div: 2'h1, acq_sel: 2'h0};
    cal = 1'b1;
    conv = 1'b1;
    @(negedge clk);
    cal = 1'b0;
    conv = 1'b0;
    sfr(ABS_STATUS_ADDR, 8'h00, 1'b0);
    chk("cal_busy", {4'h0, d}, 12'h080);
    while (busy && n < 2000) begin
      @(negedge clk);
      n++;
    end
    range("cal_len", n + 2, 14 * 4, 17 * 4 + 4);
    chk("cal_no_done", {11'h0, done}, 12'h000);
    sfr(ABS_STATUS_ADDR, 8'h00, 1'b0);
    chk("cal_clear", {4'h0, d}, 12'h000);
  endtask : calibrate

  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : complete_run

  initial begin
    rst = 1'b1;
    conv = 1'b0;
    cal = 1'b0;
    cmp = 1'b0;
    req = '0;
    cfg = '0;
    tgt = 12'h000;
    repeat (4) @(negedge clk);
    rst = 1'b0;
    reset_state();
    write_busy();
    convert(12'hfff, 2'h0, 2'h0);
    convert(12'ha5c, 2'h1, 2'h3);
    convert(12'h000, 2'h3, 2'h1);
    convert(12'h801, 2'h2, 2'h2);
    calibrate();
    write_busy();
    complete_run();
  end
endmodule : test_abs_top

// *** verilog/abs_clk_div.sv ***
`timescale 1ns/1ps
module abs_clk_div (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [abs_pkg::ABS_DIV_W-1:0] sel_i,
  output logic tick_o
);
  import abs_pkg::*;
  logic [3:0] cnt_q;
  logic [3:0] limit;

  // divide ratio 2,4,8,16 selected by software
  always_comb begin
    limit = 4'((4'h2 << sel_i) - 4'h1);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 4'h0;
      tick_o <= 1'b0;
    end else if (cnt_q >= limit) begin
      cnt_q <= 4'h0;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      tick_o <= 1'b0;
    end
  end
endmodule : abs_clk_div

// *** verilog/abs_pkg.sv ***
package abs_pkg;
  // special-function bus map
  localparam logic [7:0] ABS_STATUS_ADDR = 8'hf5;
  localparam logic [7:0] ABS_STATUS_RESET = 8'h00;
  localparam int ABS_BUSY_BIT = 7;
  localparam int ABS_RESULT_W = 12;
  // timing in converter clocks
  localparam logic [3:0] ABS_CONV_CLKS = 4'hf;
  localparam logic [3:0] ABS_SYNC_CLKS = 4'h1;
  localparam int ABS_DIV_W = 2;
  localparam int ABS_ACQ_W = 2;
  localparam int ABS_CNT_W = 4;

  typedef enum logic [2:0] {
    ABS_IDLE = 3'b000,
    ABS_SYNC = 3'b001,
    ABS_TRACK = 3'b010,
    ABS_HOLD = 3'b011,
    ABS_CAL = 3'b100
  } abs_state_type;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } abs_sfr_req_type;

  typedef struct packed {
    logic [ABS_DIV_W-1:0] clk_div;
    logic [ABS_ACQ_W-1:0] acq_sel;
  } abs_cfg_type;
endpackage : abs_pkg

// *** verilog/abs_top.sv ***
`timescale 1ns/1ps
// Summary of operation
// - bit 7 of the status register reads high while conversion or calibration runs.
// - the busy bit clears itself when conversion or calibration ends.
// - status bits 6..0 always read zero.
// - status register lives at address f5 and resets to 00.
// - each conversion is a track phase followed by a hold phase stepping the SAR.
// - the final SAR value is latched out as the result when hold ends.
// - sequencing is automatic, with acquisition and clock rate set by software.
// - the result is a 12-bit code.
// - a conversion is 1 sync clock, 1 to 4 track clocks and 15 hold clocks.
module abs_top (
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // special-function bus
  input wire abs_pkg::abs_sfr_req_type SFR_REQ_I,
  output logic [7:0] SFR_RDATA_O,
  // control
  input wire logic CONV_START_I,
  input wire logic CAL_START_I,
  input wire abs_pkg::abs_cfg_type CFG_I,
  // analog front end
  input wire logic CMP_I,
  output logic TRACK_O,
  output logic [abs_pkg::ABS_RESULT_W-1:0] DAC_CODE_O,
  // results
  output logic [abs_pkg::ABS_RESULT_W-1:0] RESULT_O,
  output logic DONE_O,
  output logic BUSY_O
);
  import abs_pkg::*;

  abs_state_type state_q;
  logic tick;
  logic [ABS_CNT_W-1:0] cnt_q;
  logic [ABS_RESULT_W-1:0] sar_q;
  logic [ABS_RESULT_W-1:0] trial_q;
  logic [ABS_ACQ_W-1:0] acq_q;
  logic busy_q;
  logic pend_conv_q;
  logic pend_cal_q;
  logic status_rd;

  abs_clk_div u_div (
    .clk_i(CORE_CLK_I),
    .rst_i(RST_I),
    .sel_i(CFG_I.clk_div),
    .tick_o(tick)
  );

  // starts are caught at core rate and held until the next converter clock
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      pend_conv_q <= 1'b0;
      pend_cal_q <= 1'b0;
    end else if (tick && state_q == ABS_IDLE) begin
      pend_conv_q <= 1'b0;
      pend_cal_q <= 1'b0;
    end else begin
      if (CONV_START_I && !busy_q) pend_conv_q <= 1'b1;
      if (CAL_START_I && !busy_q) pend_cal_q <= 1'b1;
    end
  end

  // sequencer advances only on converter clock enables
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      state_q <= ABS_IDLE;
      cnt_q <= '0;
      acq_q <= '0;
      sar_q <= '0;
      trial_q <= '0;
    end else if (tick) begin
      case (state_q)
        ABS_IDLE: begin
          if (pend_cal_q) begin
            state_q <= ABS_CAL;
            cnt_q <= ABS_CONV_CLKS;
          end else if (pend_conv_q) begin
            state_q <= ABS_SYNC;
            cnt_q <= ABS_SYNC_CLKS;
            acq_q <= CFG_I.acq_sel;
          end
        end
        ABS_SYNC: begin
          if (cnt_q == ABS_SYNC_CLKS) begin
            state_q <= ABS_TRACK;
            cnt_q <= ABS_CNT_W'(acq_q);
          end
        end
        ABS_TRACK: begin
          if (cnt_q == '0) begin
            state_q <= ABS_HOLD;
            cnt_q <= ABS_CONV_CLKS - 4'h1;
            sar_q <= '0;
            trial_q <= 12'h800;
          end else begin
            cnt_q <= cnt_q - 4'h1;
          end
        end
        ABS_HOLD: begin
          // first 12 clocks decide bits, last 3 settle and latch
          if (trial_q != '0) begin
            if (!CMP_I) sar_q <= sar_q | trial_q;
            trial_q <= trial_q >> 1;
          end
          if (cnt_q == '0) state_q <= ABS_IDLE;
          else cnt_q <= cnt_q - 4'h1;
        end
        ABS_CAL: begin
          if (cnt_q == 4'h1) state_q <= ABS_IDLE;
          else cnt_q <= cnt_q - 4'h1;
        end
        default: state_q <= ABS_IDLE;
      endcase
    end
  end

  // busy covers the pending start through the final converter clock
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      busy_q <= 1'b0;
    end else begin
      busy_q <= (state_q != ABS_IDLE) || pend_conv_q || pend_cal_q;
    end
  end

  // result latch and done pulse
  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      RESULT_O <= '0;
      DONE_O <= 1'b0;
    end else begin
      DONE_O <= 1'b0;
      if (tick && state_q == ABS_HOLD && cnt_q == '0) begin
        RESULT_O <= sar_q;
        DONE_O <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      TRACK_O <= 1'b0;
      DAC_CODE_O <= '0;
      BUSY_O <= 1'b0;
    end else begin
      TRACK_O <= (state_q == ABS_TRACK) || (state_q == ABS_SYNC);
      DAC_CODE_O <= sar_q | trial_q;
      BUSY_O <= busy_q;
    end
  end

  // status read; writes are ignored since every bit is hardware owned
  assign status_rd = SFR_REQ_I.rd && SFR_REQ_I.addr == ABS_STATUS_ADDR;

  always_ff @(posedge CORE_CLK_I) begin
    if (RST_I) begin
      SFR_RDATA_O <= ABS_STATUS_RESET;
    end else if (status_rd) begin
      SFR_RDATA_O <= {busy_q, 7'h00};
    end else begin
      SFR_RDATA_O <= 8'h00;
    end
  end

  a_busy_in_hold: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (state_q == ABS_HOLD) |=> busy_q)
    else $error("busy low during conversion");
  a_busy_clears: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (state_q == ABS_IDLE && !pend_conv_q && !pend_cal_q) |=> !busy_q)
    else $error("busy stuck after finish");
  a_rsvd_zero: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    SFR_RDATA_O[6:0] == 7'h00)
    else $error("reserved bits nonzero");
  a_read_busy: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    status_rd |=> SFR_RDATA_O[ABS_BUSY_BIT] == $past(busy_q))
    else $error("status read wrong");
  a_track_hold: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (tick && state_q == ABS_TRACK && cnt_q == '0) |=> state_q == ABS_HOLD)
    else $error("track did not go to hold");
  a_result_latch: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (tick && state_q == ABS_HOLD && cnt_q == '0)
      |=> DONE_O && RESULT_O == $past(sar_q))
    else $error("result not latched");
  a_sync_one: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (tick && state_q == ABS_SYNC) |=> state_q == ABS_TRACK)
    else $error("sync longer than one clock");
  a_write_noeff: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (SFR_REQ_I.wr && state_q == ABS_IDLE && !pend_conv_q && !pend_cal_q
      && !CONV_START_I && !CAL_START_I) |=> !busy_q)
    else $error("write set busy");
  a_hold_len: assert property (@(posedge CORE_CLK_I) disable iff (RST_I)
    (tick && state_q == ABS_TRACK && cnt_q == '0)
      |=> cnt_q == ABS_CONV_CLKS - 4'h1)
    else $error("hold length wrong");
endmodule : abs_top
